// >>> hw/rbx_exec.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - a return jump loads the program counter with the recorded return address.
// RULE2 - a return jump is opcode 010111 with the immediate bit set and takes 4 clocks.
// RULE3 - return, call and jump-and-record share one opcode and differ only in bits and fields.
// RULE4 - with write-result the return acts as a call, writing PC+1 into dest bits 8:0 only.
// RULE5 - without write-result the destination register is not modified.
// RULE6 - with carry effect the return sets carry unless PC+1 wraps to zero.
// RULE7 - bit reverse mirrors the low 32-minus-Bits bits into the low end of the result.
// RULE8 - bit reverse clears the upper Bits bits of the result.
// RULE9 - Bits comes from the source register or a 5-bit literal per the immediate bit.
// RULE10 - with zero effect, bit reverse sets zero exactly when the result is zero.
// RULE11 - with carry effect, bit reverse sets carry to the original destination bit 0.
// RULE12 - bit reverse writes back unless no-result is given, leaving only flags changing.
// RULE13 - bit reverse is field 001111 under condition 1111 and takes 4 clocks.
// RULE14 - rotate left rotates the destination left by Bits positions.
// RULE15 - a register-sourced count uses only its low five bits.
module rbx_exec #(
	// edges from the take to the edge that first samples done high; the phase counter is two bits wide
	parameter int unsigned EXEC_CLKS = rbx_pkg::EXEC_CLKS
) (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        start_i,
	input  wire logic [31:0] instr_i,
	input  wire logic [31:0] dst_val_i,
	input  wire logic [31:0] src_val_i,
	input  wire logic [8:0]  pc_i,
	output logic             busy_o,
	output logic             done_o,
	output logic [8:0]       pc_o,
	output logic             pc_load_o,
	output logic             wr_en_o,
	output logic [8:0]       wr_addr_o,
	output logic [31:0]      wr_data_o,
	output logic             z_we_o,
	output logic             z_o,
	output logic             c_we_o,
	output logic             c_o
);
	localparam logic [1:0] LAST_PH      = 2'(EXEC_CLKS - 1);
	localparam int         TAKE_TO_DONE = EXEC_CLKS;
	localparam int         TAKE_TO_IDLE = EXEC_CLKS - 1;

	// one clock would need a bypass around the capture stage, more than four a wider phase
	if ((EXEC_CLKS < 2) || (EXEC_CLKS > 4)) begin : g_clks_check
		$error("EXEC_CLKS must lie between 2 and 4");
	end

	rbx_pkg::rbx_state_t state_q, state_d;
	logic [1:0]  phase_q;
	logic        busy_q, pc_load_q, wr_en_q, z_we_q, z_q, c_we_q, c_q, done_q;
	logic [8:0]  pc_q, wr_addr_q;
	logic [31:0] wr_data_q;
	// operands and wr_addr_q are captured at the take; the other outputs except busy are registered at the last phase
	logic        jmp_q, brev_q, rotl_q, fz_q, fc_q, fr_q, dbit0_q, dbit31_q;
	logic [8:0]  tgt_q, inc_q;
	logic [31:0] res_q, callw_q;

	function automatic logic [31:0] mirror(input logic [31:0] v);
		for (int i = 0; i < 32; i++) begin
			mirror[i] = v[31 - i];
		end
	endfunction : mirror

	wire logic [5:0]  op      = instr_i[rbx_pkg::OP_LSB +: 6];
	wire logic [3:0]  cond    = instr_i[rbx_pkg::CON_LSB +: 4];
	wire logic        f_z     = instr_i[rbx_pkg::ZF_BIT];
	wire logic        f_c     = instr_i[rbx_pkg::CF_BIT];
	wire logic        f_r     = instr_i[rbx_pkg::RW_BIT];
	wire logic        f_i     = instr_i[rbx_pkg::IM_BIT];
	wire logic [8:0]  dst_a   = instr_i[rbx_pkg::DST_LSB +: 9];
	wire logic [8:0]  src_f   = instr_i[rbx_pkg::SRC_LSB +: 9];
	wire logic        cond_ok = (cond == rbx_pkg::CON_ALWAYS);
	// jump family: target is the source operand; return sets immediate with a recorded s-field
	wire logic        is_jmp  = cond_ok && (op == rbx_pkg::OP_JUMP); // [RULE2] [RULE3]
	wire logic        is_brev = cond_ok && (op == rbx_pkg::OP_BREV); // [RULE13]
	wire logic        is_rotl = cond_ok && (op == rbx_pkg::OP_ROTL);
	wire logic [8:0]  target  = f_i ? src_f : src_val_i[8:0]; // [RULE1]
	// wraps at the top of the 9-bit space, which is what clears the return carry
	wire logic [8:0]  pc_inc  = pc_i + 9'h001;
	// only low five bits count, whether literal or register
	wire logic [4:0]  bits    = f_i ? src_f[4:0] : src_val_i[4:0]; // [RULE9] [RULE15]
	// mirror whole word then shift down: top Bits fall off as zeros
	wire logic [31:0] brv_res = mirror(dst_val_i) >> bits; // [RULE7] [RULE8]
	wire logic [63:0] rl_dbl  = {dst_val_i, dst_val_i} << bits;
	wire logic [31:0] rl_res  = rl_dbl[63:32]; // [RULE14]
	// call keeps dest bits 31:9
	wire logic [31:0] call_w  = {dst_val_i[31:9], pc_inc}; // [RULE4]
	wire logic [31:0] alu_res = is_brev ? brv_res : rl_res;
	wire logic        accept  = start_i && (state_q == rbx_pkg::RBX_IDLE);
	wire logic        finish  = (state_q == rbx_pkg::RBX_BUSY) && (phase_q == LAST_PH);
	// words outside the three handled kinds still finish and reload data and flag values, but raise no enable
	wire logic        run_ok  = finish && (jmp_q || brev_q || rotl_q);
	wire logic [31:0] out_w   = jmp_q ? callw_q : res_q;
	wire logic        c_shift = brev_q ? dbit0_q : dbit31_q; // [RULE11]
	wire logic        c_next  = jmp_q ? (inc_q != 9'h000) : c_shift; // [RULE6]

	always_comb begin
		case (state_q)
			rbx_pkg::RBX_IDLE: state_d = accept ? rbx_pkg::RBX_BUSY : rbx_pkg::RBX_IDLE;
			rbx_pkg::RBX_BUSY: state_d = finish ? rbx_pkg::RBX_IDLE : rbx_pkg::RBX_BUSY;
			default:           state_d = rbx_pkg::RBX_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= rbx_pkg::RBX_IDLE;
			phase_q <= 2'h0;
			{jmp_q, brev_q, rotl_q, fz_q, fc_q, fr_q, dbit0_q, dbit31_q} <= 8'h00;
			tgt_q <= 9'h000;
			inc_q <= 9'h000;
			res_q <= 32'h0000_0000;
			callw_q <= 32'h0000_0000;
			wr_addr_q <= 9'h000;
		end else begin
			state_q <= state_d;
			phase_q <= accept ? 2'h1 : (finish ? 2'h0 : phase_q + 2'h1); // [RULE2] [RULE13]
			if (accept) begin
				{jmp_q, brev_q, rotl_q} <= {is_jmp, is_brev, is_rotl};
				{fz_q, fc_q, fr_q} <= {f_z, f_c, f_r};
				{dbit0_q, dbit31_q} <= {dst_val_i[0], dst_val_i[31]};
				tgt_q <= target;
				inc_q <= pc_inc;
				res_q <= alu_res;
				callw_q <= call_w;
				wr_addr_q <= dst_a;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			{done_q, busy_q, pc_load_q, wr_en_q, z_we_q, z_q, c_we_q, c_q} <= 8'h00;
			pc_q <= rbx_pkg::PC_RST;
			wr_data_q <= 32'h0000_0000;
		end else begin
			done_q <= finish;
			busy_q <= (state_d == rbx_pkg::RBX_BUSY); // [RULE2]
			pc_load_q <= finish && jmp_q; // [RULE1]
			// write only with write-result; otherwise destination untouched
			wr_en_q <= run_ok && fr_q; // [RULE4] [RULE5] [RULE12]
			z_we_q <= run_ok && fz_q;
			c_we_q <= run_ok && fc_q;
			// values stand from one finish to the next so a late reader still sees them
			if (finish) begin
				if (jmp_q) begin
					pc_q <= tgt_q; // [RULE1]
				end
				wr_data_q <= out_w;
				z_q <= (out_w == 32'h0000_0000); // [RULE10]
				c_q <= c_next; // [RULE6] [RULE11]
			end
		end
	end

	assign busy_o    = busy_q;
	assign done_o    = done_q;
	assign pc_o      = pc_q;
	assign pc_load_o = pc_load_q;
	assign wr_en_o   = wr_en_q;
	assign wr_addr_o = wr_addr_q;
	assign wr_data_o = wr_data_q;
	assign z_we_o    = z_we_q;
	assign z_o       = z_q;
	assign c_we_o    = c_we_q;
	assign c_o       = c_q;

	// every check starts at the take edge; the answer is sampled TAKE_TO_DONE edges later
	sequence take_s;
		accept;
	endsequence

	sequence take_jump_s;
		accept && is_jmp;
	endsequence

	sequence take_brev_s;
		accept && is_brev;
	endsequence

	sequence take_other_s;
		accept && !(is_jmp || is_brev || is_rotl);
	endsequence

	four_clk_a : assert property (@(posedge clk_i) disable iff (reset_i) // [RULE2] [RULE13]
		take_s |-> ##TAKE_TO_DONE done_o)
		else $error("done not on the fourth clock");

	busy_span_a : assert property (@(posedge clk_i) disable iff (reset_i) // [RULE2]
		take_s |-> ##1 busy_o ##TAKE_TO_IDLE !busy_o)
		else $error("busy span wrong");

	pc_load_a : assert property (@(posedge clk_i) disable iff (reset_i) // [RULE1]
		take_jump_s |-> ##TAKE_TO_DONE pc_load_o && (pc_o == $past(target, TAKE_TO_DONE)))
		else $error("return target not loaded");

	ret_carry_a : assert property (@(posedge clk_i) disable iff (reset_i) // [RULE6]
		take_jump_s |-> ##TAKE_TO_DONE c_o == ($past(pc_i, TAKE_TO_DONE) != 9'h1FF))
		else $error("return carry wrong");

	call_keep_a : assert property (@(posedge clk_i) disable iff (reset_i) // [RULE4]
		take_jump_s ##0 f_r |-> ##TAKE_TO_DONE wr_en_o
			&& (wr_data_o[31:9] == $past(dst_val_i[31:9], TAKE_TO_DONE))
			&& (wr_data_o[8:0] == 9'($past(pc_i, TAKE_TO_DONE) + 9'h001)))
		else $error("call write data wrong");

	no_write_a : assert property (@(posedge clk_i) disable iff (reset_i) // [RULE5] [RULE12]
		take_s ##0 !f_r |-> ##TAKE_TO_DONE !wr_en_o)
		else $error("unexpected write");

	brev_zero_a : assert property (@(posedge clk_i) disable iff (reset_i) // [RULE10]
		take_brev_s ##0 f_z |-> ##TAKE_TO_DONE z_we_o
			&& (z_o == (wr_data_o == 32'h0000_0000)))
		else $error("reverse zero flag wrong");

	brev_carry_a : assert property (@(posedge clk_i) disable iff (reset_i) // [RULE11]
		take_brev_s ##0 f_c |-> ##TAKE_TO_DONE c_we_o
			&& (c_o == $past(dst_val_i[0], TAKE_TO_DONE)))
		else $error("reverse carry wrong");

	brev_top_a : assert property (@(posedge clk_i) disable iff (reset_i) // [RULE7] [RULE8]
		take_brev_s ##0 (bits == 5'h1F) |-> ##TAKE_TO_DONE (wr_data_o[31:1] == 31'h0000_0000)
			&& (wr_data_o[0] == $past(dst_val_i[0], TAKE_TO_DONE)))
		else $error("reverse upper bits not cleared");

	cond_skip_a : assert property (@(posedge clk_i) disable iff (reset_i) // [RULE13]
		take_other_s |-> ##TAKE_TO_DONE done_o && !(wr_en_o || z_we_o || c_we_o || pc_load_o))
		else $error("unhandled word had an effect");
endmodule : rbx_exec

// >>> hw/rbx_pkg.sv
package rbx_pkg;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned ADDR_W     = 9;
	localparam int unsigned CNT_W      = 5;
	// instruction field layout
	localparam int unsigned OP_LSB     = 26;
	localparam int unsigned ZF_BIT     = 25;
	localparam int unsigned CF_BIT     = 24;
	localparam int unsigned RW_BIT     = 23;
	localparam int unsigned IM_BIT     = 22;
	localparam int unsigned CON_LSB    = 18;
	localparam int unsigned DST_LSB    = 9;
	localparam int unsigned SRC_LSB    = 0;
	localparam logic [5:0]  OP_JUMP    = 6'h17;
	localparam logic [5:0]  OP_BREV    = 6'h0F;
	localparam logic [5:0]  OP_ROTL    = 6'h09;
	localparam logic [3:0]  CON_ALWAYS = 4'hF;
	// every handled instruction takes the same time
	localparam int unsigned EXEC_CLKS  = 4;
	localparam logic [1:0]  LAST_PHASE = 2'(EXEC_CLKS - 1);
	localparam logic [8:0]  PC_RST     = 9'h000;
	typedef enum logic [1:0] {
		RBX_IDLE = 2'b00,
		RBX_BUSY = 2'b01
	} rbx_state_t;
endpackage : rbx_pkg

// >>> verif/rbx_exec_bench.sv
`timescale 1ns/1ps
module rbx_exec_bench;
	logic        clk_i, reset_i, start_i, busy_o, done_o, pc_load_o;
	logic        wr_en_o, z_we_o, z_o, c_we_o, c_o;
	logic [31:0] instr_i, dst_val_i, src_val_i, wr_data_o;
	logic [8:0]  pc_i, pc_o, wr_addr_o;
	int          err_total, compares, cyc;
	rbx_exec rbx_exec_inst (.clk_i(clk_i), .reset_i(reset_i), .start_i(start_i),
		.instr_i(instr_i), .dst_val_i(dst_val_i), .src_val_i(src_val_i), .pc_i(pc_i),
		.busy_o(busy_o), .done_o(done_o), .pc_o(pc_o), .pc_load_o(pc_load_o),
		.wr_en_o(wr_en_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
		.z_we_o(z_we_o), .z_o(z_o), .c_we_o(c_we_o), .c_o(c_o));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("compares %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	// dest field fixed at 0AB so the write address is always known
	function automatic logic [31:0] mk(logic [5:0] op, logic [3:0] zcri, logic [3:0] con,
		logic [8:0] s);
		return {op, zcri, con, 9'h0AB, s};
	endfunction : mk
	function automatic logic [31:0] mirror(logic [31:0] d, int bits);
		logic [31:0] r;
		r = 32'h0000_0000;
		for (int k = 0; k < 32 - bits; k++) r[k] = d[31 - bits - k];
		return r;
	endfunction : mirror
	// one instruction: outputs change at the third edge past the take, checked high just after that edge
	task automatic run(input logic [31:0] ins, input logic [31:0] d, input logic [31:0] s,
		input logic [8:0] pc);
		@(posedge clk_i);
		#1 {start_i, instr_i, dst_val_i, src_val_i, pc_i} = {1'b1, ins, d, s, pc};
		@(posedge clk_i);
		#1 start_i = 1'b0;
		chk(busy_o, 1'b1);
		repeat (rbx_pkg::EXEC_CLKS - 2) @(posedge clk_i);
		#1 chk(done_o, 1'b0);
		@(posedge clk_i);
		#1 chk(done_o, 1'b1);
		chk(busy_o, 1'b0);
	endtask : run
	task automatic t_mirror();
		int cnt [5] = '{31, 28, 24, 16, 0};
		foreach (cnt[k]) begin
			run(mk(6'h0F, 4'hF, 4'hF, 9'(cnt[k])), 32'h8421_DECA, 32'h0, 9'h000);
			chk(wr_data_o, mirror(32'h8421_DECA, cnt[k]));
			chk({wr_en_o, wr_addr_o, z_we_o, c_we_o, c_o}, {1'b1, 9'h0AB, 3'b110});
			chk(z_o, cnt[k] == 31);
		end
		// register count with junk above bit 4 still means 28
		run(mk(6'h0F, 4'hE, 4'hF, 9'h000), 32'h4321_8765, 32'hFFFF_FFFC, 9'h000);
		chk({wr_data_o, c_o, z_o}, {32'h0000_000A, 2'b10});
	endtask : t_mirror
	task automatic t_noresult();
		run(mk(6'h0F, 4'hD, 4'hF, 9'h001), 32'h0000_0001, 32'h0, 9'h000);
		chk({wr_en_o, z_we_o, z_o, c_we_o, c_o}, 5'b01011);
	endtask : t_noresult
	task automatic t_jump();
		run(mk(6'h17, 4'h1, 4'hF, 9'h055), 32'hFFFF_FFFF, 32'h0, 9'h010);
		chk({pc_load_o, pc_o, wr_en_o}, {1'b1, 9'h055, 1'b0});
		run(mk(6'h17, 4'h6, 4'hF, 9'h000), 32'hFFFF_FFFF, 32'h0000_0123, 9'h010);
		chk({pc_load_o, pc_o, wr_en_o, c_o}, {1'b1, 9'h123, 2'b11});
		chk(wr_data_o, 32'hFFFF_FE11);
		run(mk(6'h17, 4'h7, 4'hF, 9'h000), 32'h0000_0000, 32'h0000_0040, 9'h1FF);
		chk({wr_data_o, c_o, z_o}, {32'h0, 2'b01});
	endtask : t_jump
	task automatic t_rotate();
		run(mk(6'h09, 4'hF, 4'hF, 9'h004), 32'h8765_4321, 32'h0, 9'h000);
		chk({wr_data_o, c_o, z_o}, {32'h7654_3218, 2'b10});
	endtask : t_rotate
	task automatic t_cond();
		run(mk(6'h0F, 4'hF, 4'h0, 9'h000), 32'h1234_5678, 32'h0, 9'h000);
		chk({wr_en_o, z_we_o, c_we_o, pc_load_o}, 4'h0);
	endtask : t_cond
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			tally_and_finish();
		end
	end
	initial begin
		{reset_i, start_i, instr_i, dst_val_i, src_val_i, pc_i} = {2'b10, 105'h0};
		repeat (6) @(posedge clk_i);
		#1 reset_i = 1'b0;
		t_mirror();
		t_noresult();
		t_jump();
		t_rotate();
		t_cond();
		tally_and_finish();
	end
endmodule : rbx_exec_bench
